/* include/aasl_consts.vh */
// Constants for the axis address and status indicator block.
// Included by the design files; holds definitions only.
`ifndef AASL_CONSTS_VH
`define AASL_CONSTS_VH

// APB register byte offsets
`define AASL_OFF_ADDR        12'h000
`define AASL_OFF_STRAP       12'h004
`define AASL_OFF_CTRL        12'h008
`define AASL_OFF_STATUS      12'h00c
`define AASL_OFF_IRQ_STAT    12'h010
`define AASL_OFF_IRQ_MASK    12'h014

// Address packing
`define AASL_CODE_W          3
`define AASL_HIGH_LSB        6
`define AASL_MID_LSB         3
`define AASL_LOW_LSB         0
`define AASL_DEFAULT_ADDR    9'h0ff
`define AASL_DEFAULT_ALIAS   16'h0000
`define AASL_ADDR_KEEP_MASK  9'h0ff

// Control register fields
`define AASL_CTRL_INIT_DONE  0
`define AASL_CTRL_ERR_SET    1
`define AASL_CTRL_BUS_RUN    2
`define AASL_CTRL_BUS_ERR    3
`define AASL_CTRL_ERR_CLR    4
`define AASL_CTRL_RESET      5'h00

// Status register fields
`define AASL_STAT_READY      0
`define AASL_STAT_ERROR      1
`define AASL_STAT_LINK_IN    2
`define AASL_STAT_LINK_OUT   3

// Interrupt bits
`define AASL_IRQ_ADDR_CHG    0
`define AASL_IRQ_ERROR       1
`define AASL_IRQ_LINK        2
`define AASL_IRQ_W           3
`define AASL_IRQ_RESET       3'h0

// Strap settling: 1000 ns must pass with a stable code
`define AASL_SETTLE_NS       1000
`define AASL_CLK_NS          10
`define AASL_SETTLE_CYC      ((`AASL_SETTLE_NS + `AASL_CLK_NS - 1) / `AASL_CLK_NS)

// Activity indicator blink hold: 50000 ns
`define AASL_ACT_NS          50000
`define AASL_ACT_CYC         (`AASL_ACT_NS / `AASL_CLK_NS)

`endif

/* design/aasl_strap_quant.v */
// Quantises one strap pin into a 3-bit code and debounces it.
// Assumes an ADC sample word already synchronised to ref_clk.
`timescale 1ns/1ps
`include "aasl_consts.vh"

module aasl_strap_quant #(
   parameter SAMPLE_W = 12,
   parameter [SAMPLE_W-1:0] T1 = 12'h292,
   parameter [SAMPLE_W-1:0] T2 = 12'h6d6,
   parameter [SAMPLE_W-1:0] T3 = 12'h9be,
   parameter [SAMPLE_W-1:0] T4 = 12'hbc7,
   parameter [SAMPLE_W-1:0] T5 = 12'hd55,
   parameter [SAMPLE_W-1:0] T6 = 12'he97,
   parameter [SAMPLE_W-1:0] T7 = 12'hf9c,
   parameter SETTLE_CYC = `AASL_SETTLE_CYC
) (
   input  wire                  ref_clk,
   input  wire                  rst_n,
   input  wire [SAMPLE_W-1:0]   sample,
   output reg  [2:0]            code,
   output reg                   settled
);
   reg  [2:0]  raw;
   reg  [2:0]  cand;
   reg  [15:0] stable_cnt;

   // R8: band to code
   always @* begin
      if (sample < T1)
         raw = 3'h0;
      else if (sample < T2)
         raw = 3'h1;
      else if (sample < T3)
         raw = 3'h2;
      else if (sample < T4)
         raw = 3'h3;
      else if (sample < T5)
         raw = 3'h4;
      else if (sample < T6)
         raw = 3'h5;
      else if (sample < T7)
         raw = 3'h6;
      else
         raw = 3'h7;
   end

   // Code only moves after it held still, so noise near a band edge is ignored
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cand       <= 3'h0;
         stable_cnt <= 16'h0000;
         code       <= 3'h0;
         settled    <= 1'b0;
      end else if (raw != cand) begin
         cand       <= raw;
         stable_cnt <= 16'h0000;
      end else if (stable_cnt == SETTLE_CYC[15:0] - 16'h0001) begin
         code    <= cand;
         settled <= 1'b1;
      end else begin
         stable_cnt <= stable_cnt + 16'h0001;
      end
   end
endmodule

/* design/aasl_top.v */
// Axis address from three straps, station alias and status indicators.
// Assumes strap samples from ADCs in another domain, link levels from PHYs, APB master.
// How it works
// R1: Address packs high code at bits 8:6, mid 5:3, low 2:0.
// R2: All straps at ground gives address 255 and station alias 0.
// R3: Bit 8 of the packed word is dropped from the address.
// R4: Ready lights after init completes, goes dark on any error.
// R5: Error indicator lights while an error condition stands.
// R6: Separate link/activity indicator for input and output fieldbus port.
// R7: Fieldbus run and error indicators are separate active-high outputs.
// R8: Each strap voltage maps to code 0..7 in rising band order.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "aasl_consts.vh"

module aasl_top #(
   parameter SAMPLE_W = 12,
   parameter ACT_CYC  = `AASL_ACT_CYC
) (
   input  wire                  ref_clk,
   input  wire                  rst_n,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [11:0]           paddr,
   input  wire [31:0]           pwdata,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   input  wire [SAMPLE_W-1:0]   strap_sample_low,
   input  wire [SAMPLE_W-1:0]   strap_sample_mid,
   input  wire [SAMPLE_W-1:0]   strap_sample_high,
   input  wire                  in_port_link,
   input  wire                  in_port_activity,
   input  wire                  out_port_link,
   input  wire                  out_port_activity,
   input  wire                  fault_in,
   output reg  [7:0]            axis_address,
   output reg  [15:0]           station_alias,
   output reg                   drive_ready_led,
   output reg                   drive_error_led,
   output reg                   in_port_link_activity_led,
   output reg                   out_port_link_activity_led,
   output reg                   fieldbus_run_led,
   output reg                   fieldbus_error_led,
   output reg                   irq
);
   // Two-stage synchronisers for the strap samples and the link, activity and fault pins arriving from outside
   reg  [SAMPLE_W-1:0] low_s1, low_s2, mid_s1, mid_s2, high_s1, high_s2;
   reg  [4:0]          pin_s1, pin_s2;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_s1  <= {SAMPLE_W{1'b0}};
         low_s2  <= {SAMPLE_W{1'b0}};
         mid_s1  <= {SAMPLE_W{1'b0}};
         mid_s2  <= {SAMPLE_W{1'b0}};
         high_s1 <= {SAMPLE_W{1'b0}};
         high_s2 <= {SAMPLE_W{1'b0}};
         pin_s1  <= 5'h00;
         pin_s2  <= 5'h00;
      end else begin
         low_s1  <= strap_sample_low;
         low_s2  <= low_s1;
         mid_s1  <= strap_sample_mid;
         mid_s2  <= mid_s1;
         high_s1 <= strap_sample_high;
         high_s2 <= high_s1;
         pin_s1  <= {fault_in, out_port_activity, out_port_link,
                     in_port_activity, in_port_link};
         pin_s2  <= pin_s1;
      end
   end

   wire in_link  = pin_s2[0];
   wire in_act   = pin_s2[1];
   wire out_link = pin_s2[2];
   wire out_act  = pin_s2[3];
   wire fault    = pin_s2[4];

   wire [2:0] strap_code_low, strap_code_mid, strap_code_high;
   wire       set_low, set_mid, set_high;

   // R8: quantise each strap
   aasl_strap_quant #(.SAMPLE_W(SAMPLE_W)) u_q_low (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .sample  (low_s2),
      .code    (strap_code_low),
      .settled (set_low)
   );
   aasl_strap_quant #(.SAMPLE_W(SAMPLE_W)) u_q_mid (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .sample  (mid_s2),
      .code    (strap_code_mid),
      .settled (set_mid)
   );
   aasl_strap_quant #(.SAMPLE_W(SAMPLE_W)) u_q_high (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .sample  (high_s2),
      .code    (strap_code_high),
      .settled (set_high)
   );

   wire all_settled = set_low & set_mid & set_high;

   // R1: weight 64, 8, 1
   wire [8:0] axis_address_select = {strap_code_high, strap_code_mid, strap_code_low};
   wire       all_unstrapped = (axis_address_select == 9'h000);
   reg  [8:0] next_addr9;
   reg  [7:0] next_axis_address;
   reg  [15:0] next_alias;

   always @* begin
      // R2: unstrapped default
      if (all_unstrapped) begin
         next_addr9 = `AASL_DEFAULT_ADDR;
         next_alias = `AASL_DEFAULT_ALIAS;
      end else begin
         next_addr9 = axis_address_select;
         next_alias = {7'h00, axis_address_select};
      end
      // R3: drop bit 8
      next_axis_address = next_addr9[7:0];
   end

   // Control register
   reg  [4:0] ctrl;
   wire init_done = ctrl[`AASL_CTRL_INIT_DONE];
   wire sw_err    = ctrl[`AASL_CTRL_ERR_SET];
   reg        err_latched;
   wire       error_now = fault | sw_err | err_latched;

   // APB decode; single-wait-free slave, answers in the access cycle
   wire apb_acc = psel & penable;
   wire apb_wr  = apb_acc & pwrite;
   wire hit_addr = (paddr == `AASL_OFF_ADDR);
   wire hit_strap = (paddr == `AASL_OFF_STRAP);
   wire hit_ctrl = (paddr == `AASL_OFF_CTRL);
   wire hit_stat = (paddr == `AASL_OFF_STATUS);
   wire hit_istat = (paddr == `AASL_OFF_IRQ_STAT);
   wire hit_imask = (paddr == `AASL_OFF_IRQ_MASK);
   wire mapped = hit_addr | hit_strap | hit_ctrl | hit_stat | hit_istat | hit_imask;

   reg  [`AASL_IRQ_W-1:0] irq_stat;
   reg  [`AASL_IRQ_W-1:0] irq_mask;
   reg  [7:0]             addr_prev;
   reg                    addr_valid;
   reg                    error_prev;
   reg  [1:0]             link_prev;
   wire [`AASL_IRQ_W-1:0] irq_event;

   assign irq_event[`AASL_IRQ_ADDR_CHG] = addr_valid & (next_axis_address != addr_prev);
   assign irq_event[`AASL_IRQ_ERROR]    = error_now & ~error_prev;
   assign irq_event[`AASL_IRQ_LINK]     = ({out_link, in_link} != link_prev);

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl        <= `AASL_CTRL_RESET;
         err_latched <= 1'b0;
         irq_mask    <= `AASL_IRQ_RESET;
         irq_stat    <= `AASL_IRQ_RESET;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         prdata      <= 32'h0000_0000;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= 32'h0000_0000;
         // Faults stick until software clears them
         if (fault)
            err_latched <= 1'b1;
         else if (apb_wr & pready & hit_ctrl & pwdata[`AASL_CTRL_ERR_CLR])
            err_latched <= 1'b0;
         if (apb_wr & pready & hit_ctrl)
            ctrl <= {1'b0, pwdata[3:0]};
         if (apb_wr & pready & hit_imask)
            irq_mask <= pwdata[`AASL_IRQ_W-1:0];
         // Set wins over write-one-to-clear
         if (apb_wr & pready & hit_istat)
            irq_stat <= (irq_stat & ~pwdata[`AASL_IRQ_W-1:0]) | irq_event;
         else
            irq_stat <= irq_stat | irq_event;
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `AASL_OFF_ADDR:     prdata <= {7'h00, axis_address_select[8], axis_address,
                                              station_alias};
               `AASL_OFF_STRAP:    prdata <= {22'h000000, all_settled, 9'h000} |
                                             {23'h000000, axis_address_select};
               `AASL_OFF_CTRL:     prdata <= {27'h0000000, err_latched, ctrl[3:0]};
               `AASL_OFF_STATUS:   prdata <= {28'h0000000, out_link, in_link,
                                              drive_error_led, drive_ready_led};
               `AASL_OFF_IRQ_STAT: prdata <= {29'h00000000, irq_stat};
               `AASL_OFF_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
               default:            prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // R6: activity blink hold per port
   reg [15:0] in_hold, out_hold;
   reg        in_blink, out_blink;

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_hold   <= 16'h0000;
         out_hold  <= 16'h0000;
         in_blink  <= 1'b0;
         out_blink <= 1'b0;
      end else begin
         if (in_hold != 16'h0000)
            in_hold <= in_hold - 16'h0001;
         else if (in_act) begin
            in_hold  <= ACT_CYC[15:0];
            in_blink <= ~in_blink;
         end else
            in_blink <= 1'b0;
         if (out_hold != 16'h0000)
            out_hold <= out_hold - 16'h0001;
         else if (out_act) begin
            out_hold  <= ACT_CYC[15:0];
            out_blink <= ~out_blink;
         end else
            out_blink <= 1'b0;
      end
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         axis_address               <= 8'h00;
         station_alias              <= 16'h0000;
         addr_prev                  <= 8'h00;
         addr_valid                 <= 1'b0;
         error_prev                 <= 1'b0;
         link_prev                  <= 2'h0;
         drive_ready_led            <= 1'b0;
         drive_error_led            <= 1'b0;
         in_port_link_activity_led  <= 1'b0;
         out_port_link_activity_led <= 1'b0;
         fieldbus_run_led           <= 1'b0;
         fieldbus_error_led         <= 1'b0;
         irq                        <= 1'b0;
      end else begin
         if (all_settled) begin
            axis_address  <= next_axis_address;
            station_alias <= next_alias;
            addr_prev     <= next_axis_address;
            addr_valid    <= 1'b1;
         end
         error_prev <= error_now;
         link_prev  <= {out_link, in_link};
         // R4: ready after init, off on error
         drive_ready_led <= init_done & all_settled & ~error_now;
         // R5: error indicator
         drive_error_led <= error_now;
         // R6: link steady, blinks on traffic
         in_port_link_activity_led  <= in_link & ~in_blink;
         out_port_link_activity_led <= out_link & ~out_blink;
         // R7: separate fieldbus indicators
         fieldbus_run_led   <= ctrl[`AASL_CTRL_BUS_RUN];
         fieldbus_error_led <= ctrl[`AASL_CTRL_BUS_ERR];
         irq <= |(irq_stat & irq_mask);
      end
   end
endmodule

/* dv/aasl_top_monitor.sv */
// Concurrent checks on the axis address block, seeing only top ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module aasl_top_monitor #(
   parameter SAMPLE_W = 12,
   parameter ACT_CYC  = 8
) (
   input wire        ref_clk,
   input wire        rst_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        fault_in,
   input wire        in_port_link,
   input wire        out_port_link,
   input wire [7:0]  axis_address,
   input wire [15:0] station_alias,
   input wire        drive_ready_led,
   input wire        drive_error_led,
   input wire        in_port_link_activity_led,
   input wire        out_port_link_activity_led,
   input wire        fieldbus_run_led,
   input wire        fieldbus_error_led
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   chk_addr_pack: assert property (station_alias != 16'h0000 |->
      axis_address == station_alias[7:0]) else $error("address not low alias byte");
   chk_alias_width: assert property (station_alias[15:9] == 7'h00)
      else $error("alias wider than packed word");
   chk_default_addr: assert property ((station_alias == 16'h0000 && axis_address != 8'h00)
      |-> axis_address == 8'hff) else $error("default address not 255");
   chk_ready_dark: assert property (drive_error_led |-> !drive_ready_led)
      else $error("ready lit during error");
   chk_fault_error: assert property ($rose(fault_in) |-> ##[1:6] drive_error_led)
      else $error("fault did not light error");
   chk_in_link_off: assert property (!in_port_link [*5] |-> !in_port_link_activity_led)
      else $error("input port led lit without link");
   chk_out_link_off: assert property (!out_port_link [*5] |-> !out_port_link_activity_led)
      else $error("output port led lit without link");
   chk_bus_run: assert property ((psel && penable && pready && pwrite && paddr == 12'h008)
      |-> ##2 fieldbus_run_led == $past(pwdata[2], 2)) else $error("run led not ctrl bit");
   chk_bus_error: assert property ((psel && penable && pready && pwrite && paddr == 12'h008)
      |-> ##2 fieldbus_error_led == $past(pwdata[3], 2)) else $error("bus error led wrong");
endmodule

bind aasl_top aasl_top_monitor #(.SAMPLE_W(SAMPLE_W), .ACT_CYC(ACT_CYC)) aasl_top_monitor_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .fault_in(fault_in),
   .in_port_link(in_port_link), .out_port_link(out_port_link),
   .axis_address(axis_address), .station_alias(station_alias),
   .drive_ready_led(drive_ready_led), .drive_error_led(drive_error_led),
   .in_port_link_activity_led(in_port_link_activity_led),
   .out_port_link_activity_led(out_port_link_activity_led),
   .fieldbus_run_led(fieldbus_run_led), .fieldbus_error_led(fieldbus_error_led));

/* dv/aasl_strap_pins.sv */
// Strap resistors seen through the ADC: one sample word per strap code.
// Assumes a 12-bit ADC at 3.3 V full scale; values sit at nominal band voltages.
`timescale 1ns/1ps
module aasl_strap_pins #(
   parameter SAMPLE_W = 12
) (
   input  wire [2:0]          code_low,
   input  wire [2:0]          code_mid,
   input  wire [2:0]          code_high,
   output wire [SAMPLE_W-1:0] sample_low,
   output wire [SAMPLE_W-1:0] sample_mid,
   output wire [SAMPLE_W-1:0] sample_high
);
   function automatic logic [SAMPLE_W-1:0] level(input logic [2:0] c);
      case (c)
         3'h0: level = 12'h000;
         3'h1: level = 12'h523;
         3'h2: level = 12'h888;
         3'h3: level = 12'hae8;
         3'h4: level = 12'hc9a;
         3'h5: level = 12'he02;
         3'h6: level = 12'hf2c;
         default: level = 12'hfff;
      endcase
   endfunction
   assign sample_low  = level(code_low);
   assign sample_mid  = level(code_mid);
   assign sample_high = level(code_high);
endmodule

/* dv/axis_address_and_status_leds_bench.sv */
// Self-checking bench for the axis address and indicator block.
// Assumes an APB slave that raises pready in time and a short activity hold.
`timescale 1ns/1ps
module axis_address_and_status_leds_bench;
   logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rerr;
   logic [11:0] paddr = 12'h000, s_low, s_mid, s_high;
   logic [31:0] pwdata = 32'h0, rdata;
   logic [2:0] c_low = 3'h0, c_mid = 3'h0, c_high = 3'h0;
   logic in_link = 1'h0, in_act = 1'h0, out_link = 1'h0, out_act = 1'h0, fault = 1'h0;
   wire [31:0] prdata;
   wire [7:0] axis_address;
   wire [15:0] station_alias;
   wire pready, pslverr, irq, rdy, err, in_led, out_led, run_led, ferr_led;
   int miscompares = 0, checked = 0;

   always #5 ref_clk = ~ref_clk;

   aasl_strap_pins aasl_strap_pins_i (.code_low(c_low), .code_mid(c_mid), .code_high(c_high),
      .sample_low(s_low), .sample_mid(s_mid), .sample_high(s_high));
   aasl_top #(.ACT_CYC(8)) aasl_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .strap_sample_low(s_low), .strap_sample_mid(s_mid),
      .strap_sample_high(s_high), .in_port_link(in_link), .in_port_activity(in_act),
      .out_port_link(out_link), .out_port_activity(out_act), .fault_in(fault),
      .axis_address(axis_address), .station_alias(station_alias), .drive_ready_led(rdy),
      .drive_error_led(err), .in_port_link_activity_led(in_led),
      .out_port_link_activity_led(out_led), .fieldbus_run_led(run_led),
      .fieldbus_error_led(ferr_led), .irq(irq));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         report_and_stop;
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   // Model: packed word, bit 8 dropped, all-zero default
   task automatic strap(input logic [2:0] l, input logic [2:0] m, input logic [2:0] h);
      int p, ea;
      @(posedge ref_clk);
      c_low <= l;
      c_mid <= m;
      c_high <= h;
      wt(130);
      p = 64 * h + 8 * m + l;
      ea = (p == 0) ? 255 : p % 256;
      chk(axis_address, ea);
      chk(station_alias, p);
      apb(1'h0, 12'h000, 32'h0);
      chk(rdata, (p / 256) * 32'h100_0000 + ea * 32'h1_0000 + p);
      apb(1'h0, 12'h004, 32'h0);
      chk(rdata, 32'h200 + p);
   endtask

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      report_and_stop;
   end

   initial begin
      void'($urandom(57));
      wt(5);
      rst_n <= 1'h1;
      strap(3'h0, 3'h0, 3'h0);
      for (int k = 0; k < 8; k++) strap(3'(k), 3'(7 - k), 3'(k));
      repeat (3) strap(3'($urandom), 3'($urandom), 3'($urandom));
      $display("test straps done");
      apb(1'h0, 12'h020, 32'h0);
      chk(rerr, 1'h1);
      chk(rdata, 32'h0);
      apb(1'h1, 12'h008, 32'h1);
      wt(4);
      chk({err, rdy}, 2'h1);
      @(posedge ref_clk);
      fault <= 1'h1;
      wt(8);
      chk({irq, err, rdy}, 3'h2);
      apb(1'h1, 12'h014, 32'h2);
      wt(3);
      chk(irq, 1'h1);
      @(posedge ref_clk);
      fault <= 1'h0;
      wt(8);
      chk(err, 1'h1);
      apb(1'h1, 12'h008, 32'h11);
      apb(1'h1, 12'h010, 32'h2);
      wt(4);
      chk({irq, err, rdy}, 3'h1);
      $display("test ready and error done");
      for (int i = 0; i < 4; i++) begin
         apb(1'h1, 12'h008, 32'(i * 4 + 1));
         wt(3);
         chk({ferr_led, run_led}, 32'(i));
      end
      $display("test fieldbus leds done");
      @(posedge ref_clk);
      in_link <= 1'h1;
      wt(6);
      chk({in_led, out_led}, 2'h2);
      @(posedge ref_clk);
      in_link <= 1'h0;
      out_link <= 1'h1;
      wt(6);
      chk({in_led, out_led}, 2'h1);
      @(posedge ref_clk);
      out_act <= 1'h1;
      wt(5);
      chk(out_led, 1'h0);
      out_act <= 1'h0;
      wt(12);
      chk(out_led, 1'h1);
      apb(1'h0, 12'h00c, 32'h0);
      chk(rdata, 32'h9);
      apb(1'h0, 12'h010, 32'h0);
      chk(rdata, 32'h5);
      $display("test link leds done");
      report_and_stop;
   end
endmodule
